/* File: rtl/ldie_top.sv */
/*
  led driver interrupt enable: event flags, enables, sink-off group select
  and the host interrupt line with its optional deassert gap.
  assumes the serial bus decoder presents one-cycle read and write strobes
  with an address and byte, synchronous to clk; event inputs are one-cycle
  pulses and diode states are levels, all synchronous to clk.
*/
// Overview of operation
// - enable bit 6 gates the all-selected-sinks-off flag onto the interrupt
// - enable bit 5 raises the interrupt whenever a backlight fade-out ends
// - fade-out end means automated fade-out done or dimming profile done
// - enable bit 4 gates short flag; flag still sets when disabled
// - enable bit 3 gates thermal flag; flag still sets when disabled
// - enable bit 2 gates overvoltage flag; flag still sets when disabled
// - select bit 0 of high register puts diode 9 in off group
// - sinks-off flag sets when all selected diodes are off after at least one selected diode was on
// - flags clear only by writing one; zero writes and reads keep them
// - with config bit set, clearing with events pending gives 50 us gap
`timescale 1ns/1ns
`default_nettype none
module ldie_top
  import ldie_pkg::*;
#(
  parameter int GapCycles = ldie_pkg::GAP_CYCLES
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // register access from the serial bus decoder
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  output var  logic [7:0] regRdData,
  // event sources
  input  wire logic       fadeOutDone,
  input  wire logic       dimProfileDone,
  input  wire logic       shortDetect,
  input  wire logic       thermalDetect,
  input  wire logic       overvoltageDetect,
  input  wire logic [8:0] diodeOn,
  // host interrupt, active low
  output var  logic       hostIrqN
);
  import ldie_pkg::*;

  logic [7:0]          flags;
  logic [7:0]          enable;
  logic [7:0]          selHi;
  logic [7:0]          selLo;
  logic                irqCfg;
  logic                armed;
  ldie_state_e         state;
  logic [GAP_CNT_W-1:0] gapCnt;

  logic [7:0]          next_flags;
  logic [7:0]          next_enable;
  logic [7:0]          next_selHi;
  logic [7:0]          next_selLo;
  logic                next_irqCfg;
  logic                next_armed;
  logic [7:0]          next_regRdData;
  ldie_state_e         next_state;
  logic [GAP_CNT_W-1:0] next_gapCnt;
  logic                next_hostIrqN;

  logic [8:0]          groupSel;
  logic                anySelOn;
  logic                sinksOffEvent;
  logic [7:0]          setVec;
  logic [7:0]          clrVec;
  logic                clearHit;
  logic [7:0]          pending;
  logic                nextPending;

  function automatic logic wrTo(input logic [7:0] a);
    wrTo = regWrEn && (regAddr == a);
  endfunction : wrTo

  function automatic logic [7:0] readMux(input logic [7:0] a);
    case (a)
      REG_MODE:   readMux = {1'b0, irqCfg, 6'h00};
      REG_STATUS: readMux = flags & EVENT_MASK;
      REG_ENABLE: readMux = enable & EVENT_MASK;
      REG_SEL_HI: readMux = selHi & SEL_HI_MASK;
      REG_SEL_LO: readMux = selLo;
      default:    readMux = 8'h00;
    endcase
  endfunction : readMux

  // event detection and register file
  always_comb begin
    groupSel      = {selHi[BIT_DIODE9], selLo};
    anySelOn      = |(diodeOn & groupSel);
    sinksOffEvent = armed && !anySelOn && (groupSel != 9'h000);
    next_armed    = anySelOn ? 1'b1 : (sinksOffEvent ? 1'b0 : armed);
    setVec        = 8'h00;
    setVec[BIT_SINKS_OFF]   = sinksOffEvent;
    setVec[BIT_BACKLIGHT]   = fadeOutDone || dimProfileDone;
    setVec[BIT_SHORT]       = shortDetect;
    setVec[BIT_THERMAL]     = thermalDetect;
    setVec[BIT_OVERVOLTAGE] = overvoltageDetect;
    // write one to clear, set wins
    clrVec      = wrTo(REG_STATUS) ? (regWrData & EVENT_MASK) : 8'h00;
    next_flags  = ((flags & ~clrVec) | setVec) & EVENT_MASK;
    next_enable = wrTo(REG_ENABLE) ? (regWrData & EVENT_MASK) : enable;
    next_selHi  = wrTo(REG_SEL_HI) ? (regWrData & SEL_HI_MASK) : selHi;
    next_selLo  = wrTo(REG_SEL_LO) ? regWrData : selLo;
    next_irqCfg = wrTo(REG_MODE) ? regWrData[BIT_IRQ_CFG] : irqCfg;
    next_regRdData = regRdEn ? readMux(regAddr) : regRdData;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags     <= RST_FLAGS;
      enable    <= RST_ENABLE;
      selHi     <= RST_SEL_HI;
      selLo     <= RST_SEL_LO;
      irqCfg    <= RST_CFG;
      armed     <= 1'b0;
      regRdData <= 8'h00;
    end else begin
      flags     <= next_flags;
      enable    <= next_enable;
      selHi     <= next_selHi;
      selLo     <= next_selLo;
      irqCfg    <= next_irqCfg;
      armed     <= next_armed;
      regRdData <= next_regRdData;
    end
  end

  // interrupt line state machine
  always_comb begin
    pending     = flags & enable & EVENT_MASK;
    nextPending = |(next_flags & next_enable);
    clearHit    = |(clrVec & pending);
    next_state  = state;
    next_gapCnt = gapCnt;
    case (state)
      ST_QUIET: begin
        if (nextPending) begin
          next_state = ST_ASSERT;
        end
      end
      ST_ASSERT: begin
        if (!nextPending) begin
          next_state = ST_QUIET;
        end else if (clearHit && irqCfg) begin
          next_state  = ST_GAP;
          next_gapCnt = '0;
        end
      end
      ST_GAP: begin
        next_gapCnt = gapCnt + 1'b1;
        if (gapCnt == GAP_CNT_W'(GapCycles - 1)) begin
          next_state = nextPending ? ST_ASSERT : ST_QUIET;
        end
      end
      default: begin
        next_state = ST_QUIET;
      end
    endcase
    next_hostIrqN = (next_state != ST_ASSERT);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state    <= ST_QUIET;
      gapCnt   <= '0;
      hostIrqN <= 1'b1;
    end else begin
      state    <= next_state;
      gapCnt   <= next_gapCnt;
      hostIrqN <= next_hostIrqN;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_clear_with_pending;
    state == ST_ASSERT && clearHit && irqCfg && nextPending;
  endsequence

  sequence s_line_off_8;
    hostIrqN [*8];
  endsequence

  a_gap_after_clear: assert property (s_clear_with_pending |=> s_line_off_8)
    else $error("interrupt line did not drop after clear with pending events");
  a_cfg0_stays_on: assert property (state == ST_ASSERT && clearHit && !irqCfg && nextPending |=> !hostIrqN)
    else $error("interrupt line dropped with gap disabled");
  a_line_tracks_pending: assert property (state != ST_GAP |-> hostIrqN == !(|pending))
    else $error("interrupt line does not match enabled flags");
  a_short_set_always: assert property (shortDetect |=> flags[BIT_SHORT])
    else $error("short flag not set on detection");
  a_thermal_set_always: assert property (thermalDetect |=> flags[BIT_THERMAL])
    else $error("thermal flag not set on detection");
  a_overvolt_set_always: assert property (overvoltageDetect |=> flags[BIT_OVERVOLTAGE])
    else $error("overvoltage flag not set on detection");
  a_backlight_both_ends: assert property (fadeOutDone || dimProfileDone |=> flags[BIT_BACKLIGHT])
    else $error("backlight flag not set at fade-out end");
  a_backlight_irq: assert property (enable[BIT_BACKLIGHT] && flags[BIT_BACKLIGHT] && state != ST_GAP |-> !hostIrqN)
    else $error("backlight flag enabled but line not asserted");
  a_sinks_off_set: assert property (armed && !anySelOn && groupSel != 9'h000 |=> flags[BIT_SINKS_OFF])
    else $error("sinks-off flag not set when group went off");
  a_sinks_irq_gate: assert property (!enable[BIT_SINKS_OFF] && flags == 8'h40 |-> hostIrqN)
    else $error("sinks-off flag raised line while disabled");
  a_diode9_excluded: assert property (!selHi[BIT_DIODE9] && diodeOn == 9'h100 |-> !anySelOn)
    else $error("diode 9 counted while excluded");
  a_zero_write_keeps: assert property (wrTo(REG_STATUS) && !regWrData[BIT_SHORT] && flags[BIT_SHORT]
                                       |=> flags[BIT_SHORT])
    else $error("flag lost without a one written");
  a_one_write_clears: assert property (wrTo(REG_STATUS) && regWrData[BIT_THERMAL] && !thermalDetect
                                       |=> !flags[BIT_THERMAL])
    else $error("flag not cleared by writing one");
  a_reserved_zero: assert property (regRdEn && regAddr == REG_STATUS |=> regRdData[7] == 1'b0 && regRdData[1:0] == 2'h0)
    else $error("reserved status bits read nonzero");
endmodule : ldie_top
`default_nettype wire

/* File: rtl/ldie_pkg.sv */
/*
  constants for the led driver interrupt enable block: register offsets,
  field positions, reset values and the interrupt gap timing.
  assumes a 125 MHz system clock.
*/
package ldie_pkg;
  // register offsets
  localparam logic [7:0] REG_MODE      = 8'h01;
  localparam logic [7:0] REG_STATUS    = 8'h02;
  localparam logic [7:0] REG_ENABLE    = 8'h03;
  localparam logic [7:0] REG_SEL_HI    = 8'h04;
  localparam logic [7:0] REG_SEL_LO    = 8'h05;
  // field positions: event bits shared by status and enable registers, then the mode and select bits
  localparam int BIT_SINKS_OFF   = 6;
  localparam int BIT_BACKLIGHT   = 5;
  localparam int BIT_SHORT       = 4;
  localparam int BIT_THERMAL     = 3;
  localparam int BIT_OVERVOLTAGE = 2;
  localparam int BIT_IRQ_CFG     = 6;
  localparam int BIT_DIODE9      = 0;
  // implemented bits, all others read zero
  localparam logic [7:0] EVENT_MASK  = 8'h7C;
  localparam logic [7:0] SEL_HI_MASK = 8'h01;
  // reset values
  localparam logic [7:0] RST_FLAGS  = 8'h00;
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_SEL_HI = 8'h00;
  localparam logic [7:0] RST_SEL_LO = 8'h00;
  localparam logic       RST_CFG    = 1'b0;
  // interrupt gap timing
  localparam int CLK_MHZ     = 125;
  localparam int GAP_TIME_US = 50;
  localparam int GAP_CYCLES  = GAP_TIME_US * CLK_MHZ;
  localparam int GAP_CNT_W   = 13;

  typedef enum logic [2:0] {
    ST_QUIET  = 3'b001,
    ST_ASSERT = 3'b010,
    ST_GAP    = 3'b100
  } ldie_state_e;
endpackage : ldie_pkg

/* File: testbench/ldie_host_model.sv */
/*
  host model: drives the register strobes of the block, one byte per call.
  assumes clk is the block's clock; the bench calls wr and rd.
*/
`timescale 1ns/1ns
`default_nettype none
module ldie_host_model (
  // clock and read data
  input  wire logic       clk,
  input  wire logic [7:0] regRdData,
  // register strobes
  output var  logic [7:0] regAddr,
  output var  logic [7:0] regWrData,
  output var  logic       regWrEn,
  output var  logic       regRdEn
);
  initial begin
    regAddr   = 8'h00;
    regWrData = 8'h00;
    regWrEn   = 1'b0;
    regRdEn   = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr   = a;
    regWrData = d;
    regWrEn   = 1'b1;
    @(negedge clk);
    regWrEn   = 1'b0;
    regAddr   = ~a;
    regWrData = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk);
    regRdEn = 1'b0;
    regAddr = ~a;
    d       = regRdData;
  endtask : rd
endmodule : ldie_host_model
`default_nettype wire

/* File: testbench/led_driver_interrupt_enable_bench.sv */
/*
  bench: host model drives registers, bench drives events and diodes,
  integer model predicts reads and the interrupt line. gap shortened to 10.
*/
`timescale 1ns/1ns
`default_nettype none
module led_driver_interrupt_enable_bench;
  import ldie_pkg::*;
  localparam int Gap = 10;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] addr, wdat, rdat, r, v;
  logic       wen, ren, irqN;
  logic [4:0] evt = 5'h00;
  logic [8:0] don = 9'h000;
  int         fail_count = 0, checked = 0, seed = 93592, flg = 0, en = 0, b;
  int         bitOf [5] = '{5, 5, 4, 3, 2};
  always #4 clk = ~clk;
  ldie_top #(.GapCycles(Gap)) u_ldie_top (.clk(clk), .rst(rst), .regAddr(addr), .regWrData(wdat),
    .regWrEn(wen), .regRdEn(ren), .regRdData(rdat), .fadeOutDone(evt[0]), .dimProfileDone(evt[1]),
    .shortDetect(evt[2]), .thermalDetect(evt[3]), .overvoltageDetect(evt[4]), .diodeOn(don),
    .hostIrqN(irqN));
  ldie_host_model u_ldie_host_model (.clk(clk), .regRdData(rdat), .regAddr(addr),
    .regWrData(wdat), .regWrEn(wen), .regRdEn(ren));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic irq_chk();
    chk({7'h00, irqN}, ((flg & en) != 0) ? 8'h00 : 8'h01);
  endtask : irq_chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    u_ldie_host_model.rd(a, r);
    chk(r, e);
  endtask : rchk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_ldie_host_model.wr(a, d);
  endtask : wr
  task automatic pulse(input int k);
    @(negedge clk);
    evt[k] = 1'b1;
    @(negedge clk);
    evt[k] = 1'b0;
    flg |= 1 << bitOf[k];
  endtask : pulse
  task automatic summarize();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  initial begin
    #100000;
    fail_count++;
    summarize();
  end
  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    for (int a = 1; a < 8; a++) rchk(a[7:0], 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      wr(REG_ENABLE, v);
      rchk(REG_ENABLE, v & EVENT_MASK);
      wr(REG_SEL_HI, v);
      rchk(REG_SEL_HI, v & SEL_HI_MASK);
      wr(REG_SEL_LO, v);
      rchk(REG_SEL_LO, v);
      wr(8'h07, v);
      rchk(8'h07, 8'h00);
    end
    wr(REG_ENABLE, 8'h00);
    $display("test registers done");
    for (int k = 0; k < 5; k++) begin
      b = bitOf[k];
      en = 0;
      // earlier pass left its enable on
      wr(REG_ENABLE, 8'h00);
      pulse(k);
      irq_chk();
      rchk(REG_STATUS, 8'(1 << b));
      en = 1 << b;
      wr(REG_ENABLE, 8'(en));
      irq_chk();
      wr(REG_STATUS, 8'h00);
      rchk(REG_STATUS, 8'(1 << b));
      irq_chk();
      wr(REG_STATUS, 8'(1 << b));
      flg = 0;
      irq_chk();
    end
    $display("test events done");
    en = 8'h40;
    wr(REG_ENABLE, 8'h40);
    wr(REG_SEL_HI, 8'h01);
    wr(REG_SEL_LO, 8'h00);
    @(negedge clk) don = 9'h100;
    repeat (2) @(negedge clk);
    don = 9'h000;
    repeat (2) @(negedge clk);
    flg = 8'h40;
    irq_chk();
    rchk(REG_STATUS, 8'h40);
    wr(REG_STATUS, 8'h40);
    flg = 0;
    en = 0;
    wr(REG_ENABLE, 8'h00);
    wr(REG_SEL_HI, 8'h00);
    wr(REG_SEL_LO, 8'h01);
    @(negedge clk) don = 9'h101;
    repeat (2) @(negedge clk);
    // diode 9 stays on but is outside the group
    don = 9'h100;
    repeat (2) @(negedge clk);
    flg = 8'h40;
    rchk(REG_STATUS, 8'h40);
    irq_chk();
    wr(REG_STATUS, 8'h40);
    flg = 0;
    don = 9'h000;
    repeat (2) @(negedge clk);
    rchk(REG_STATUS, 8'h00);
    $display("test sinks done");
    wr(REG_MODE, 8'h40);
    en = 8'h18;
    wr(REG_ENABLE, 8'h18);
    pulse(2);
    pulse(3);
    irq_chk();
    wr(REG_STATUS, 8'h10);
    flg = 8'h08;
    repeat (Gap - 2) begin
      chk({7'h00, irqN}, 8'h01);
      @(negedge clk);
    end
    repeat (3) @(negedge clk);
    irq_chk();
    wr(REG_MODE, 8'h00);
    pulse(2);
    wr(REG_STATUS, 8'h10);
    flg = 8'h08;
    repeat (3) begin
      irq_chk();
      @(negedge clk);
    end
    $display("test gap done");
    summarize();
  end
endmodule : led_driver_interrupt_enable_bench
`default_nettype wire
